/* hw/fcd_host.sv */
// Host-side sequencer that drives a parallel flash module through its pins.
// Assumes pin inputs synchronous to clk_sys and an outside driver for the
// high-voltage identifier level on A9.
`timescale 1ns/10ps
`default_nettype none
module fcd_host #(
    parameter int SETUP_CYC   = fcd_pkg::C_SETUP,
    parameter int WE_LOW_CYC  = fcd_pkg::C_WE_LOW,
    parameter int WE_HIGH_CYC = fcd_pkg::C_WE_HIGH,
    parameter int ACCESS_CYC  = fcd_pkg::C_ACCESS,
    parameter int RECOVER_CYC = fcd_pkg::C_RECOVER
) (
    input  wire logic        clk_sys,          // System clock
    input  wire logic        srst,             // Synchronous reset
    input  wire logic        cmd_valid,        // Request present
    input  wire logic [3:0]  cmd_op,           // Command kind
    input  wire logic [19:0] cmd_addr,         // Read, program or sector addr
    input  wire logic        cmd_bank,         // Bank-half for read/program
    input  wire logic [15:0] cmd_data,         // Program value
    output logic             cmd_ready,        // Idle, request may be taken
    output logic             cmd_refused,      // Pulse: command not allowed
    output logic             cmd_done,         // Pulse: command finished
    output logic             rsp_valid,        // Pulse: read data valid
    output logic [15:0]      rsp_data,         // Read data
    output logic             wsm_busy,         // Program or erase running
    output logic             erase_suspended,  // Erase held in suspend
    output logic [19:0]      flash_addr,       // Address pins A0-A19
    output logic             bank_half_select, // Lowest address bit
    output logic             flash_ce_n,       // Chip select
    output logic             flash_oe_n,       // Output enable
    output logic             flash_we0_n,      // Write strobe, lane 0
    output logic             flash_we1_n,      // Write strobe, lane 1
    output logic             id_high_voltage,  // Request high level on A9
    input  wire logic [15:0] dq_in,            // Data pins, read
    output logic [15:0]      dq_out,           // Data pins, drive
    output logic             dq_oe_n           // Low while driving data
);
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_GAP   = 6'h02,
        ST_ASET  = 6'h04,
        ST_WLOW  = 6'h08,
        ST_WHIGH = 6'h10,
        ST_RWAIT = 6'h20
    } fcd_state_e;

    if (SETUP_CYC < 1 || WE_LOW_CYC < 1 || WE_HIGH_CYC < 1 ||
        ACCESS_CYC < 1 || RECOVER_CYC < 1 || SETUP_CYC > 255 ||
        WE_LOW_CYC > 255 || WE_HIGH_CYC > 255 || ACCESS_CYC > 255 ||
        RECOVER_CYC > 255) begin : g_bad_timing
        $error("fcd_host: timing counts must lie in 1..255");
    end

    fcd_state_e        state_reg, state_next;
    logic [7:0]        cnt_reg, cnt_next;
    logic [2:0]        step_reg, step_next;
    logic              rd_pend_reg, rd_pend_next;
    fcd_pkg::fcd_cmd_e op_reg;
    logic [19:0]       addr_reg;
    logic              bank_reg;
    logic [15:0]       data_reg;
    logic              tick;
    logic              accept;
    logic              erase_run;
    fcd_pkg::fcd_cmd_e op_in;

    assign op_in  = fcd_pkg::fcd_cmd_e'(cmd_op);
    assign tick   = (cnt_reg == 8'h00);
    assign accept = (state_reg == ST_IDLE) && cmd_valid && allowed(op_in);

    // Number of write cycles in each sequence
    function automatic logic [2:0] writes_of(fcd_pkg::fcd_cmd_e c);
        case (c)
            fcd_pkg::CMD_READ, fcd_pkg::CMD_HV_ID: writes_of = 3'd0;
            fcd_pkg::CMD_PROGRAM:                  writes_of = 3'd4;
            fcd_pkg::CMD_CHIP, fcd_pkg::CMD_SECTOR: writes_of = 3'd6;
            default:                               writes_of = 3'd3;
        endcase
    endfunction : writes_of

    // Sequences that end with a read of the selected source
    function automatic logic reads_of(fcd_pkg::fcd_cmd_e c);
        reads_of = (c == fcd_pkg::CMD_READ) || (c == fcd_pkg::CMD_HV_ID) ||
                   (c == fcd_pkg::CMD_ID) || (c == fcd_pkg::CMD_STATUS);
    endfunction : reads_of

    // The device ignores most codes while its write machine runs, so they
    // are refused here instead of silently lost on the pins
    function automatic logic allowed(fcd_pkg::fcd_cmd_e c);
        if (erase_suspended) begin
            allowed = (c == fcd_pkg::CMD_READ) || (c == fcd_pkg::CMD_RESET) ||
                      (c == fcd_pkg::CMD_STATUS) ||
                      (c == fcd_pkg::CMD_ABORT) || (c == fcd_pkg::CMD_RESUME);
        end else if (wsm_busy && !erase_run) begin
            allowed = (c == fcd_pkg::CMD_STATUS);
        end else if (wsm_busy) begin
            allowed = (c == fcd_pkg::CMD_STATUS) ||
                      (c == fcd_pkg::CMD_SUSPEND);
        end else begin
            allowed = (c != fcd_pkg::CMD_SUSPEND);
        end
    endfunction : allowed

    // Third-cycle code of each command
    function automatic logic [7:0] code_of(fcd_pkg::fcd_cmd_e c);
        case (c)
            fcd_pkg::CMD_RESET:   code_of = fcd_pkg::CODE_RESET;
            fcd_pkg::CMD_ID:      code_of = fcd_pkg::CODE_ID;
            fcd_pkg::CMD_PROGRAM: code_of = fcd_pkg::CODE_PROGRAM;
            fcd_pkg::CMD_CHIP,
            fcd_pkg::CMD_SECTOR:  code_of = fcd_pkg::CODE_ERASE;
            fcd_pkg::CMD_SUSPEND: code_of = fcd_pkg::CODE_SUSPEND;
            fcd_pkg::CMD_RESUME:  code_of = fcd_pkg::CODE_RESUME;
            fcd_pkg::CMD_STATUS:  code_of = fcd_pkg::CODE_STATUS;
            fcd_pkg::CMD_CLEAR:   code_of = fcd_pkg::CODE_CLEAR;
            fcd_pkg::CMD_SLEEP:   code_of = fcd_pkg::CODE_SLEEP;
            default:              code_of = fcd_pkg::CODE_ABORT;
        endcase
    endfunction : code_of

    // Address of write step s; unlock addresses leave A15-A19 at zero
    function automatic logic [19:0] step_addr(logic [2:0] s);
        if ((s == 3'd3 && op_reg == fcd_pkg::CMD_PROGRAM) ||
            (s == 3'd5 && op_reg == fcd_pkg::CMD_SECTOR)) begin
            step_addr = addr_reg;
        end else if (s == 3'd1 || s == 3'd4) begin
            step_addr = fcd_pkg::UNLOCK_ADDR_2;
        end else begin
            step_addr = fcd_pkg::UNLOCK_ADDR_1;
        end
    endfunction : step_addr

    // Data of write step s; command bytes go out on both lanes
    function automatic logic [15:0] step_data(logic [2:0] s);
        logic [7:0] b;
        b = fcd_pkg::UNLOCK_DATA_1;
        if (s == 3'd1 || s == 3'd4) begin
            b = fcd_pkg::UNLOCK_DATA_2;
        end else if (s == 3'd2) begin
            b = code_of(op_reg);
        end else if (s == 3'd5) begin
            b = (op_reg == fcd_pkg::CMD_CHIP) ? fcd_pkg::CODE_CHIP
                                              : fcd_pkg::CODE_SECTOR;
        end
        if (s == 3'd3 && op_reg == fcd_pkg::CMD_PROGRAM) begin
            step_data = data_reg;
        end else begin
            step_data = {b, b};
        end
    endfunction : step_data

    // Sequencer: each write cycle is setup, strobe low, hold, then a gap; a read is access wait, then a gap
    always_comb begin
        state_next   = state_reg;
        step_next    = step_reg;
        rd_pend_next = rd_pend_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    state_next   = ST_GAP;
                    step_next    = 3'd0;
                    rd_pend_next = reads_of(op_in);
                end
            end
            ST_GAP: begin
                if (tick) begin
                    if (step_reg < writes_of(op_reg)) begin
                        state_next = ST_ASET;
                    end else if (rd_pend_reg) begin
                        state_next = ST_RWAIT;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_ASET: if (tick) state_next = ST_WLOW;
            ST_WLOW: if (tick) state_next = ST_WHIGH;
            ST_WHIGH: begin
                if (tick) begin
                    state_next = ST_GAP;
                    step_next  = step_reg + 3'd1;
                end
            end
            ST_RWAIT: begin
                if (tick) begin
                    state_next   = ST_GAP;
                    rd_pend_next = 1'b0;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (state_next == state_reg) begin
            cnt_next = tick ? 8'h00 : cnt_reg - 8'h01;
        end else begin
            case (state_next)
                ST_ASET:  cnt_next = 8'(SETUP_CYC - 1);
                ST_WLOW:  cnt_next = 8'(WE_LOW_CYC - 1);
                ST_WHIGH: cnt_next = 8'(WE_HIGH_CYC - 1);
                ST_RWAIT: cnt_next = 8'(ACCESS_CYC - 1);
                ST_GAP:   cnt_next = (state_reg == ST_IDLE) ? 8'h00
                                     : 8'(RECOVER_CYC - 1);
                default:  cnt_next = 8'h00;
            endcase
        end
    end

    // State, counter and latched request
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= 8'h00;
            step_reg    <= 3'd0;
            rd_pend_reg <= 1'b0;
            op_reg      <= fcd_pkg::CMD_READ;
            addr_reg    <= 20'h00000;
            bank_reg    <= 1'b0;
            data_reg    <= 16'h0000;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            step_reg    <= step_next;
            rd_pend_reg <= rd_pend_next;
            if (accept) begin
                op_reg   <= op_in;
                addr_reg <= cmd_addr;
                bank_reg <= cmd_bank;
                data_reg <= cmd_data;
            end
        end
    end

    // Pins follow the next state so every pin comes from a flop
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flash_addr       <= 20'h00000;
            bank_half_select <= 1'b0;
            flash_ce_n       <= 1'b1;
            flash_oe_n       <= 1'b1;
            flash_we0_n      <= 1'b1;
            flash_we1_n      <= 1'b1;
            id_high_voltage  <= 1'b0;
            dq_out           <= 16'h0000;
            dq_oe_n          <= 1'b1;
        end else begin
            flash_ce_n  <= 1'b1;
            flash_oe_n  <= 1'b1;
            flash_we0_n <= 1'b1;
            flash_we1_n <= 1'b1;
            dq_oe_n     <= 1'b1;
            case (state_next)
                ST_ASET, ST_WLOW, ST_WHIGH: begin
                    flash_ce_n <= 1'b0;
                    dq_oe_n    <= 1'b0;
                    if (state_reg == ST_GAP) begin
                        flash_addr       <= step_addr(step_next);
                        dq_out           <= step_data(step_next);
                        bank_half_select <= (op_reg == fcd_pkg::CMD_PROGRAM)
                                            && (step_next == 3'd3) && bank_reg;
                    end
                    if (state_next == ST_WLOW) begin
                        flash_we0_n <= 1'b0;
                        flash_we1_n <= 1'b0;
                    end
                end
                ST_RWAIT: begin
                    flash_ce_n <= 1'b0;
                    flash_oe_n <= 1'b0;
                    if (state_reg == ST_GAP) begin
                        if (op_reg == fcd_pkg::CMD_HV_ID) begin
                            flash_addr       <= {19'h00000, addr_reg[0]};
                            bank_half_select <= 1'b0;
                            id_high_voltage  <= 1'b1;
                        end else if (op_reg == fcd_pkg::CMD_ID) begin
                            flash_addr       <= {19'h00000, addr_reg[0]};
                            bank_half_select <= 1'b0;
                        end else begin
                            flash_addr       <= addr_reg;
                            bank_half_select <= bank_reg;
                        end
                    end
                end
                default: id_high_voltage <= 1'b0;
            endcase
        end
    end

    // Handshake and read answers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cmd_ready   <= 1'b0;
            cmd_refused <= 1'b0;
            cmd_done    <= 1'b0;
            rsp_valid   <= 1'b0;
            rsp_data    <= 16'h0000;
        end else begin
            cmd_ready   <= (state_next == ST_IDLE);
            cmd_refused <= (state_reg == ST_IDLE) && cmd_valid &&
                           !allowed(op_in);
            cmd_done    <= (state_reg == ST_GAP) && (state_next == ST_IDLE);
            rsp_valid   <= (state_reg == ST_RWAIT) && tick;
            if ((state_reg == ST_RWAIT) && tick) begin
                rsp_data <= dq_in;
            end
        end
    end

    // Track the device's write machine to know which codes it will take
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wsm_busy        <= 1'b0;
            erase_run       <= 1'b0;
            erase_suspended <= 1'b0;
        end else if (accept) begin
            case (op_in)
                fcd_pkg::CMD_PROGRAM: wsm_busy <= 1'b1;
                fcd_pkg::CMD_CHIP, fcd_pkg::CMD_SECTOR: begin
                    wsm_busy  <= 1'b1;
                    erase_run <= 1'b1;
                end
                fcd_pkg::CMD_SUSPEND: erase_suspended <= 1'b1;
                fcd_pkg::CMD_RESUME:  erase_suspended <= 1'b0;
                fcd_pkg::CMD_ABORT: begin
                    wsm_busy        <= 1'b0;
                    erase_run       <= 1'b0;
                    erase_suspended <= 1'b0;
                end
                default: ;
            endcase
        end else if ((state_reg == ST_RWAIT) && tick &&
                     (op_reg == fcd_pkg::CMD_STATUS) && !erase_suspended &&
                     dq_in[fcd_pkg::DONE_BIT_LO] &&
                     dq_in[fcd_pkg::DONE_BIT_HI]) begin
            wsm_busy  <= 1'b0;
            erase_run <= 1'b0;
        end
    end
endmodule : fcd_host
`default_nettype wire

/* shared/fcd_pkg.sv */
// Constants, command set and bus timing for the flash command sequencer.
// Assumes a 10 MHz system clock and an x16 module built from two x8 lanes.
// Function
// - Commands are plain write strobes, chip select low
// - Unlock pair AA/5555, 55/2AAA, code at 5555
// - Identifier mode ends with read/reset sequence
// - Program is unlock, A0, then address/data write
package fcd_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_SETUP_NS    = 50;   // Address and chip select to strobe
    localparam int T_WE_LOW_NS   = 100;  // Write strobe low width
    localparam int T_WE_HIGH_NS  = 50;   // Data hold after strobe rise
    localparam int T_ACCESS_NS   = 200;  // Read access time
    localparam int T_RECOVER_NS  = 50;   // Deselected gap between cycles
    // Least times, so round up to whole cycles
    localparam int C_SETUP   = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_WE_LOW  = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_WE_HIGH = (T_WE_HIGH_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int C_ACCESS  = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int C_RECOVER = (T_RECOVER_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;

    localparam logic [19:0] UNLOCK_ADDR_1 = 20'h05555;
    localparam logic [19:0] UNLOCK_ADDR_2 = 20'h02aaa;
    localparam logic [7:0]  UNLOCK_DATA_1 = 8'haa;
    localparam logic [7:0]  UNLOCK_DATA_2 = 8'h55;
    localparam logic [7:0]  CODE_RESET    = 8'hf0;
    localparam logic [7:0]  CODE_ID       = 8'h90;
    localparam logic [7:0]  CODE_PROGRAM  = 8'ha0;
    localparam logic [7:0]  CODE_ERASE    = 8'h80;
    localparam logic [7:0]  CODE_CHIP     = 8'h10;
    localparam logic [7:0]  CODE_SECTOR   = 8'h30;
    localparam logic [7:0]  CODE_SUSPEND  = 8'hb0;
    localparam logic [7:0]  CODE_RESUME   = 8'hd0;
    localparam logic [7:0]  CODE_STATUS   = 8'h70;
    localparam logic [7:0]  CODE_CLEAR    = 8'h50;
    localparam logic [7:0]  CODE_SLEEP    = 8'hc0;
    localparam logic [7:0]  CODE_ABORT    = 8'he0;
    localparam int          DONE_BIT_LO   = 7;
    localparam int          DONE_BIT_HI   = 15;

    typedef enum logic [3:0] {
        CMD_READ    = 4'h0,  // Plain array read, no writes
        CMD_HV_ID   = 4'h1,  // High-voltage identifier read
        CMD_RESET   = 4'h2,
        CMD_ID      = 4'h3,
        CMD_PROGRAM = 4'h4,
        CMD_CHIP    = 4'h5,
        CMD_SECTOR  = 4'h6,
        CMD_SUSPEND = 4'h7,
        CMD_RESUME  = 4'h8,
        CMD_STATUS  = 4'h9,
        CMD_CLEAR   = 4'ha,
        CMD_SLEEP   = 4'hb,
        CMD_ABORT   = 4'hc
    } fcd_cmd_e;
endpackage : fcd_pkg

/* tb/fcd_host_properties.sv */
// Port-level checks for the flash command sequencer.
// Assumes it is bound to fcd_host and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module fcd_host_properties (
    input wire logic        clk_sys,         // Clock
    input wire logic        srst,            // Reset
    input wire logic        cmd_valid,       // Request
    input wire logic [3:0]  cmd_op,          // Kind
    input wire logic        cmd_ready,       // Idle
    input wire logic        cmd_refused,     // Refusal
    input wire logic        wsm_busy,        // Running
    input wire logic        erase_suspended, // Held
    input wire logic [19:0] flash_addr,      // Address
    input wire logic        flash_ce_n,      // Select
    input wire logic        flash_oe_n,      // Output enable
    input wire logic        flash_we0_n,     // Strobe 0
    input wire logic        flash_we1_n,     // Strobe 1
    input wire logic        id_high_voltage, // A9 level
    input wire logic [15:0] dq_out,          // Data
    input wire logic        dq_oe_n          // Data enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic take;
    // A request is taken only while the sequencer is idle
    assign take = cmd_ready && cmd_valid;
    a_lanes_same: assert property (flash_we0_n == flash_we1_n)
        else $error("write strobes differ");
    a_write_cycle: assert property (!flash_we0_n |->
        !flash_ce_n && flash_oe_n && !dq_oe_n) else $error("bad write cycle");
    a_addr_held: assert property ($fell(flash_we0_n) |->
        $stable(flash_addr) ##1 $stable(flash_addr)) else $error("addr moved");
    a_data_held: assert property ($rose(flash_we0_n) |->
        $stable(dq_out) && !dq_oe_n) else $error("data dropped at rise");
    a_read_quiet: assert property (!flash_oe_n |->
        flash_we0_n && !flash_ce_n && dq_oe_n) else $error("read contention");
    a_hv_read: assert property (id_high_voltage |->
        flash_we0_n && !flash_addr[1]) else $error("bad id read pins");
    a_busy_refuse: assert property (take && wsm_busy &&
        !erase_suspended && cmd_op != fcd_pkg::CMD_STATUS &&
        cmd_op != fcd_pkg::CMD_SUSPEND |=> cmd_refused)
        else $error("busy command not refused");
    a_idle_suspend: assert property (take && !wsm_busy &&
        cmd_op == fcd_pkg::CMD_SUSPEND |=> cmd_refused)
        else $error("idle suspend not refused");
    a_refuse_quiet: assert property (cmd_refused |->
        cmd_ready && flash_ce_n) else $error("refusal touched pins");
    a_status_ok: assert property (take && cmd_op == fcd_pkg::CMD_STATUS
        |=> !cmd_refused) else $error("status refused");
    a_read_start: assert property (take && !wsm_busy &&
        cmd_op == fcd_pkg::CMD_READ |-> ##[1:30] !flash_oe_n)
        else $error("read never started");
    cover property (take && cmd_op == fcd_pkg::CMD_PROGRAM);
    cover property (cmd_refused);
    cover property (erase_suspended);
    cover property (id_high_voltage);
endmodule : fcd_host_properties
bind fcd_host fcd_host_properties u_props (.*);
`default_nettype wire

/* tb/fcd_flash_model.sv */
// Behavioural flash device: decodes unlock sequences on write strobes.
// Assumes both lane strobes are equal; identifier values are arbitrary.
`timescale 1ns/10ps
`default_nettype none
module fcd_flash_model #(
    parameter logic [7:0] MAKER_CODE  = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h4d, // Arbitrary value
    parameter int         BUSY_READS  = 2
) (
    input  wire logic [19:0] addr, // Address pins
    input  wire logic        bank, // Bank-half select
    input  wire logic        ce_n, // Chip select
    input  wire logic        oe_n, // Output enable
    input  wire logic        we_n, // Write strobe
    input  wire logic        hv,   // High level on A9
    input  wire logic [15:0] dq,   // Data wire
    output logic      [15:0] q     // Device drive
);
    logic [19:0] a_lat, last_addr = 20'h00000;
    logic [2:0]  step = 3'h0;
    logic [1:0]  mode = 2'h0; // Array reads from power-up
    logic [7:0]  last_code = 8'h00, d;
    logic [15:0] out;
    int          busy = 0;
    // Address latched as the strobe falls
    always @(negedge we_n) if (!ce_n) a_lat = addr;
    // Data latched as strobe rises; only A0-A14 matched
    always @(posedge we_n) if (!ce_n) begin
        d = dq[7:0];
        if (step == 3'h0 || step == 3'h4)
            step = (a_lat[14:0] == 15'h5555 && d == 8'haa) ? step + 3'h1 : '0;
        else if (step == 3'h1 || step == 3'h5)
            step = (a_lat[14:0] == 15'h2aaa && d == 8'h55) ? step + 3'h1 : '0;
        else begin
            last_code = d;
            last_addr = a_lat;
            // Final write of program or erase starts the write machine
            if (step == 3'h3 || (step == 3'h6 && (d == 8'h30
                || (d == 8'h10 && a_lat[14:0] == 15'h5555)))) begin
                busy = BUSY_READS;
                mode = 2'h2;
                step = 3'h0;
            end
            // Busy lets only status and suspend through
            if (step == 3'h2 && a_lat[14:0] == 15'h5555
                && (busy == 0 || d == 8'h70 || d == 8'hb0)) case (d)
                8'hf0: mode = 2'h0;
                8'h90: mode = 2'h1;
                8'h70: mode = 2'h2;
                8'ha0: step = 3'h3;
                8'h80: step = 3'h4;
                default: ;
            endcase
            // Only program and erase setup codes keep the sequence open
            if (step != 3'h3 && step != 3'h4) step = 3'h0;
        end
    end
    // Status is latched as output enable falls
    always @(negedge oe_n) if (!ce_n && mode == 2'h2 && busy > 0) busy--;
    always_comb begin
        if (hv || mode == 2'h1) out = {2{addr[0] ? DEVICE_CODE : MAKER_CODE}};
        else if (mode == 2'h2) out = {busy == 0, 7'h00, busy == 0, 7'h00};
        else out = {addr[14:0], bank};
    end
    // Deselected bus shows the inverse so stale data never matches
    assign q = (ce_n || oe_n) ? ~out : out;
endmodule : fcd_flash_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench: host sequencer against the behavioural flash model.
// Assumes package, design, checker and model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk_sys = 1'b0, srst = 1'b1, cmd_valid = 1'b0, cmd_bank = 1'b0;
    logic [3:0]  cmd_op = 4'h0;
    logic [19:0] cmd_addr = 20'h00000, flash_addr;
    logic [15:0] cmd_data = 16'h0000, rsp_data, dq_out, dq_dev, dq_bus, rsp;
    logic        cmd_ready, cmd_refused, cmd_done, rsp_valid, wsm_busy;
    logic        erase_suspended, bank_half_select, flash_ce_n, flash_oe_n;
    logic        flash_we0_n, flash_we1_n, id_high_voltage, dq_oe_n;
    int          n_fail = 0;
    int          n_compared = 0;
    // Host owns the data wire only while its enable is low
    assign dq_bus = dq_oe_n ? dq_dev : dq_out;
    fcd_host uut (.*, .dq_in(dq_bus));
    fcd_flash_model flash (.addr(flash_addr), .bank(bank_half_select),
        .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we0_n),
        .hv(id_high_voltage), .dq(dq_bus), .q(dq_dev));
    initial forever #50 clk_sys = ~clk_sys;
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // One request, then a bounded wait for its refusal or completion
    task automatic issue(input logic [3:0] op, input logic [19:0] a,
                         input logic [15:0] d, input logic ref_exp);
        int k;
        rsp = 16'hxxxx;
        // An edge always passes, so valid never toggles twice in one step
        for (k = 0; k < 300 && (k == 0 || cmd_ready !== 1'b1); k++)
            @(posedge clk_sys) #10;
        if (k == 300) begin
            n_fail++;
            end_sim();
        end
        {cmd_valid, cmd_op, cmd_addr, cmd_bank, cmd_data} = {1'b1, op, a, a[0], d};
        @(posedge clk_sys);
        #10;
        cmd_valid = 1'b0;
        chk(cmd_refused, ref_exp);
        for (k = 0; k < 300 && !ref_exp && cmd_done !== 1'b1; k++) begin
            @(posedge clk_sys);
            #10;
            if (rsp_valid === 1'b1) rsp = rsp_data;
        end
        if (k == 300) begin
            n_fail++;
            end_sim();
        end
    endtask : issue
    // Array read straight after reset, bank bit as lowest address bit
    task automatic t_power_read;
        issue(fcd_pkg::CMD_READ, 20'h12345, 16'h0000, 1'b0);
        chk(rsp, 16'h468b);
    endtask : t_power_read
    // Identifier by command, leave by read/reset, then by high voltage
    task automatic t_ident;
        issue(fcd_pkg::CMD_ID, 20'h00001, 16'h0000, 1'b0);
        chk(flash.last_code, 8'h90);
        chk(rsp, {2{flash.DEVICE_CODE}});
        issue(fcd_pkg::CMD_RESET, 20'h00000, 16'h0000, 1'b0);
        chk(flash.last_code, 8'hf0);
        issue(fcd_pkg::CMD_READ, 20'h00100, 16'h0000, 1'b0);
        chk(rsp, 16'h0200);
        issue(fcd_pkg::CMD_HV_ID, 20'hfff00, 16'h0000, 1'b0);
        chk(rsp, {2{flash.MAKER_CODE}});
    endtask : t_ident
    // Program, refused read while busy, status until done and beyond
    task automatic t_program;
        issue(fcd_pkg::CMD_PROGRAM, 20'h8abcd, 16'h33a5, 1'b0);
        chk(flash.last_addr, 20'h8abcd);
        chk(flash.last_code, 8'ha5);
        chk(wsm_busy, 1'b1);
        issue(fcd_pkg::CMD_READ, 20'h00000, 16'h0000, 1'b1);
        issue(fcd_pkg::CMD_STATUS, 20'h00000, 16'h0000, 1'b0);
        chk(rsp, 16'h0000);
        issue(fcd_pkg::CMD_STATUS, 20'h00000, 16'h0000, 1'b0);
        chk(rsp, 16'h8080);
        chk(wsm_busy, 1'b0);
        issue(fcd_pkg::CMD_READ, 20'h00777, 16'h0000, 1'b0);
        chk(rsp, 16'h8080);
    endtask : t_program
    // Sector erase with suspend and resume, then chip erase
    task automatic t_erase;
        issue(fcd_pkg::CMD_SECTOR, 20'h5f0f0, 16'h0000, 1'b0);
        chk(flash.last_addr[19:16], 4'h5);
        chk(flash.last_code, 8'h30);
        issue(fcd_pkg::CMD_CLEAR, 20'h00000, 16'h0000, 1'b1);
        issue(fcd_pkg::CMD_SUSPEND, 20'h00000, 16'h0000, 1'b0);
        chk(flash.last_code, 8'hb0);
        chk(erase_suspended, 1'b1);
        issue(fcd_pkg::CMD_RESUME, 20'h00000, 16'h0000, 1'b0);
        chk(erase_suspended, 1'b0);
        issue(fcd_pkg::CMD_CHIP, 20'h00000, 16'h0000, 1'b1);
        repeat (2) issue(fcd_pkg::CMD_STATUS, 20'h00000, 16'h0000, 1'b0);
        chk(wsm_busy, 1'b0);
        issue(fcd_pkg::CMD_CHIP, 20'h00000, 16'h0000, 1'b0);
        chk(flash.last_code, 8'h10);
        chk(flash.last_addr[14:0], 15'h5555);
        repeat (2) issue(fcd_pkg::CMD_STATUS, 20'h00000, 16'h0000, 1'b0);
        chk(rsp, 16'h8080);
    endtask : t_erase
    // Three-cycle codes clear, sleep, abort and resume while idle; suspend alone is refused
    task automatic t_codes;
        logic [3:0] ops [4] = '{fcd_pkg::CMD_CLEAR, fcd_pkg::CMD_SLEEP,
                               fcd_pkg::CMD_ABORT, fcd_pkg::CMD_RESUME};
        logic [7:0] codes [4] = '{8'h50, 8'hc0, 8'he0, 8'hd0};
        issue(fcd_pkg::CMD_SUSPEND, 20'h00000, 16'h0000, 1'b1);
        foreach (ops[i]) begin
            issue(ops[i], 20'h00000, 16'h0000, 1'b0);
            chk(flash.last_code, codes[i]);
        end
    endtask : t_codes
    initial begin
        repeat (12) @(posedge clk_sys);
        #10;
        srst = 1'b0;
        t_power_read();
        t_ident();
        t_program();
        t_erase();
        t_codes();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
